// ---- logic/gbs_top.sv ----
// Module: GPIO ports with data, bit-set and bit-clear registers
//
// Function
// - Port0 set bits 20..16 drive pins high
// - Set bit written zero leaves pin alone
// - Port1 set bits 17,16 drive pins high
// - Port2 set bits 22,21,17,16 drive high
// - Port0 clear bits 20..16 drive pins low
// - Port1 clear bits 17,16 drive pins low
// - Port2 clear bits 22,21,17,16 drive low
// - Clear bit written zero leaves pin alone
// - Each set/clear register: own write-only address
// - Set/clear touches only addressed pins
// - Output latch drives pins; data register shows it
// - Pin driven only when direction bit is one
//
// Added by the designer: the address-and-strobe port.
module gbs_top (
  input  wire logic        clock,
  input  wire logic        sys_rst,
  input  wire logic [31:0] bus_addr,
  input  wire logic [31:0] bus_wdata,
  input  wire logic        bus_wr,
  input  wire logic        bus_rd,
  output logic      [31:0] bus_rdata,
  input  wire logic [4:0]  port0_pin_in,
  output logic      [4:0]  port0_pin_out,
  output logic      [4:0]  port0_pin_oe,
  input  wire logic [1:0]  port1_pin_in,
  output logic      [1:0]  port1_pin_out,
  output logic      [1:0]  port1_pin_oe,
  input  wire logic [6:0]  port2_pin_in,
  output logic      [6:0]  port2_pin_out,
  output logic      [6:0]  port2_pin_oe
);

  localparam int NP = gbs_pkg::PORT_COUNT;
  localparam int PW = gbs_pkg::PIN_W;

  // ****************************************************************
  // Pin inputs widened to one port width
  // ****************************************************************
  logic [PW-1:0] pin_in_all  [NP];
  logic [PW-1:0] out_all     [NP];
  logic [PW-1:0] dir_all     [NP];
  logic [PW-1:0] in_all      [NP];
  logic [NP-1:0] data_hit;

  assign pin_in_all[0] = {2'h0, port0_pin_in};
  assign pin_in_all[1] = {5'h00, port1_pin_in};
  assign pin_in_all[2] = port2_pin_in;

  // ****************************************************************
  // Bus write fields
  // ****************************************************************
  logic [PW-1:0] wr_dir_field;
  logic [PW-1:0] wr_out_field;

  assign wr_dir_field = bus_wdata[gbs_pkg::DIR_LSB +: PW];
  assign wr_out_field = bus_wdata[gbs_pkg::OUT_LSB +: PW];

  // ****************************************************************
  // One slice per port
  // ****************************************************************
  for (genvar g = 0; g < NP; g++) begin : gen_port
    logic          set_hit;
    logic          clr_hit;
    logic [PW-1:0] set_bits;
    logic [PW-1:0] clr_bits;
    logic [PW-1:0] out_q;
    logic [PW-1:0] out_d;
    logic [PW-1:0] dir_q;
    logic [PW-1:0] dir_d;
    logic [PW-1:0] sync1_q;
    logic [PW-1:0] sync2_q;

    // Decode; each strobe reaches at most one register, none when unmapped
    assign data_hit[g] = bus_wr && (bus_addr == gbs_pkg::DATA_ADDR[g]);
    assign set_hit = bus_wr && (bus_addr == gbs_pkg::SET_ADDR[g]);
    assign clr_hit = bus_wr && (bus_addr == gbs_pkg::CLR_ADDR[g]);

    // Reserved and unimplemented bits are masked off
    assign set_bits = wr_out_field & gbs_pkg::OUT_MASK[g];
    assign clr_bits = wr_out_field & gbs_pkg::OUT_MASK[g];

    // Set ORs ones in, clear ANDs them out; zeros keep the pin
    always_comb begin
      out_d = out_q;
      dir_d = dir_q;
      if (data_hit[g]) begin
        out_d = wr_out_field & gbs_pkg::OUT_MASK[g];
        dir_d = wr_dir_field & gbs_pkg::DIR_MASK[g];
      end else if (set_hit) begin
        out_d = out_q | set_bits;
      end else if (clr_hit) begin
        out_d = out_q & ~clr_bits;
      end
    end

    always_ff @(posedge clock) begin
      if (sys_rst) begin
        out_q <= gbs_pkg::OUT_RESET;
        dir_q <= gbs_pkg::DIR_RESET;
      end else begin
        out_q <= out_d;
        dir_q <= dir_d;
      end
    end

    // Pins are asynchronous: two stages before anyone reads them
    always_ff @(posedge clock) begin
      if (sys_rst) begin
        sync1_q <= '0;
        sync2_q <= '0;
      end else begin
        sync1_q <= pin_in_all[g];
        sync2_q <= sync1_q;
      end
    end

    assign out_all[g] = out_q;
    assign dir_all[g] = dir_q;
    assign in_all[g]  = sync2_q & gbs_pkg::IN_MASK[g];
  end

  // ****************************************************************
  // Pin drivers straight from the latches
  // ****************************************************************
  logic [PW-1:0] oe_all [NP];

  for (genvar g = 0; g < NP; g++) begin : gen_oe
    assign oe_all[g] = dir_all[g] & gbs_pkg::OUT_MASK[g];
  end

  assign port0_pin_out = out_all[0][4:0];
  assign port0_pin_oe  = oe_all[0][4:0];
  assign port1_pin_out = out_all[1][1:0];
  assign port1_pin_oe  = oe_all[1][1:0];
  assign port2_pin_out = out_all[2];
  assign port2_pin_oe  = oe_all[2];

  // ****************************************************************
  // Read path; set and clear are write-only and read as zero
  // ****************************************************************
  logic [31:0] rd_value;
  logic [31:0] rdata_q;

  always_comb begin
    rd_value = gbs_pkg::RDATA_IDLE;
    for (int i = 0; i < NP; i++) begin
      if (bus_addr == gbs_pkg::DATA_ADDR[i]) begin
        rd_value = {1'b0, dir_all[i], 1'b0, out_all[i],
                    9'h000, in_all[i]};
      end
    end
  end

  // Data stands only in the cycle after the strobe
  always_ff @(posedge clock) begin
    if (sys_rst) begin
      rdata_q <= gbs_pkg::RDATA_IDLE;
    end else if (bus_rd) begin
      rdata_q <= rd_value;
    end else begin
      rdata_q <= gbs_pkg::RDATA_IDLE;
    end
  end

  assign bus_rdata = rdata_q;

endmodule

// ---- logic/gbs_pkg.sv ----
// Package: register map, field layout and masks of the GPIO port block
package gbs_pkg;

  // ****************************************************************
  // Sizes
  // ****************************************************************
  localparam int PORT_COUNT = 3;
  localparam int PIN_W      = 7;
  localparam int ADDR_W     = 32;
  localparam int DATA_W     = 32;

  // ****************************************************************
  // Register byte addresses, indexed by port number
  // ****************************************************************
  localparam logic [31:0] DATA_ADDR [PORT_COUNT] = '{
    32'hFFFF0D20, 32'hFFFF0D30, 32'hFFFF0D40
  };
  localparam logic [31:0] SET_ADDR [PORT_COUNT] = '{
    32'hFFFF0D24, 32'hFFFF0D34, 32'hFFFF0D44
  };
  localparam logic [31:0] CLR_ADDR [PORT_COUNT] = '{
    32'hFFFF0D28, 32'hFFFF0D38, 32'hFFFF0D48
  };

  // ****************************************************************
  // Field positions in data, set and clear registers
  // ****************************************************************
  localparam int DIR_LSB = 24;
  localparam int OUT_LSB = 16;
  localparam int IN_LSB  = 0;

  // ****************************************************************
  // Implemented pins per port, field by field
  // ****************************************************************
  localparam logic [PIN_W-1:0] OUT_MASK [PORT_COUNT] = '{
    7'h1F, 7'h03, 7'h63
  };
  localparam logic [PIN_W-1:0] DIR_MASK [PORT_COUNT] = '{
    7'h1F, 7'h03, 7'h73
  };
  localparam logic [PIN_W-1:0] IN_MASK [PORT_COUNT] = '{
    7'h1F, 7'h03, 7'h73
  };

  // ****************************************************************
  // Reset values
  // ****************************************************************
  localparam logic [PIN_W-1:0]  DIR_RESET  = 7'h00;
  localparam logic [PIN_W-1:0]  OUT_RESET  = 7'h00;
  localparam logic [DATA_W-1:0] RDATA_IDLE = 32'h00000000;

endpackage

// ---- verification/gbs_pin_model.sv ----
// Partner: pad model answering one port's pins
module gbs_pin_model #(
  parameter int W = 5
) (
  input  wire logic [W-1:0] pin_out,
  input  wire logic [W-1:0] pin_oe,
  output logic      [W-1:0] pin_in
);
  timeunit 1ns;
  timeprecision 1ps;
  // Undriven pad shows inverse of last level, never a stale copy
  assign pin_in = pin_out ~^ pin_oe;
endmodule

// ---- verification/gbs_asserts.sv ----
// Checker: pin response to set and clear writes
module gbs_asserts (
  input wire logic        clock,
  input wire logic        sys_rst,
  input wire logic [31:0] bus_addr,
  input wire logic [31:0] bus_wdata,
  input wire logic        bus_wr,
  input wire logic        bus_rd,
  input wire logic [31:0] bus_rdata,
  input wire logic [4:0]  port0_pin_out,
  input wire logic [1:0]  port1_pin_out,
  input wire logic [6:0]  port2_pin_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge clock); endclocking
  default disable iff (sys_rst);
  wire logic s0 = bus_wr && bus_addr == 32'hFFFF0D24;
  wire logic s1 = bus_wr && bus_addr == 32'hFFFF0D34;
  wire logic s2 = bus_wr && bus_addr == 32'hFFFF0D44;
  wire logic c0 = bus_wr && bus_addr == 32'hFFFF0D28;
  wire logic c1 = bus_wr && bus_addr == 32'hFFFF0D38;
  wire logic c2 = bus_wr && bus_addr == 32'hFFFF0D48;
  wire logic [4:0] w0 = bus_wdata[20:16];
  wire logic [6:0] w2 = bus_wdata[22:16] & 7'h63;
  property p_s0; s0 |=> &(port0_pin_out | ~$past(w0)); endproperty
  property p_s1; s1 |=> &(port1_pin_out | ~$past(bus_wdata[17:16]));
  endproperty
  property p_s2; s2 |=> &(port2_pin_out | ~$past(w2)); endproperty
  property p_c0; c0 |=> ~|(port0_pin_out & $past(w0)); endproperty
  property p_c1; c1 |=> ~|(port1_pin_out & $past(bus_wdata[17:16]));
  endproperty
  property p_c2; c2 |=> ~|(port2_pin_out & $past(w2)); endproperty
  property p_k0;
    s0 |=> ((port0_pin_out ^ $past(port0_pin_out)) & ~$past(w0)) == 5'h00;
  endproperty
  property p_k1;
    c0 |=> ((port0_pin_out ^ $past(port0_pin_out)) & ~$past(w0)) == 5'h00;
  endproperty
  property p_rd; bus_rd && bus_addr == 32'hFFFF0D24 |=> bus_rdata == '0;
  endproperty
  a_s0: assert property (p_s0) else $error("s0");
  a_s1: assert property (p_s1) else $error("s1");
  a_s2: assert property (p_s2) else $error("s2");
  a_c0: assert property (p_c0) else $error("c0");
  a_c1: assert property (p_c1) else $error("c1");
  a_c2: assert property (p_c2) else $error("c2");
  a_k0: assert property (p_k0) else $error("k0");
  a_k1: assert property (p_k1) else $error("k1");
  a_rd: assert property (p_rd) else $error("rd");
  cover property (s2);
  cover property (c2);
  cover property (c1);
endmodule

bind gbs_top gbs_asserts u_chk (.clock(clock), .sys_rst(sys_rst),
  .bus_addr(bus_addr), .bus_wdata(bus_wdata), .bus_wr(bus_wr),
  .bus_rd(bus_rd), .bus_rdata(bus_rdata), .port0_pin_out(port0_pin_out),
  .port1_pin_out(port1_pin_out), .port2_pin_out(port2_pin_out));

// ---- verification/gbs_top_tb.sv ----
// Bench: set, clear and readback per port, plus unmapped access at FFFF0D2C
module gbs_top_tb;
  timeunit 1ns;
  timeprecision 1ps;
  logic        clock = 0, sys_rst = 1, bus_wr = 0, bus_rd = 0;
  logic [31:0] bus_addr = '0, bus_wdata = '0, bus_rdata;
  logic [4:0]  i0, o0, e0;
  logic [1:0]  i1, o1, e1;
  logic [6:0]  i2, o2, e2, po [3], pe [3];
  int          fail_count = 0, n_tests = 0;
  assign po = '{{2'h0, o0}, {5'h00, o1}, o2};
  assign pe = '{{2'h0, e0}, {5'h00, e1}, e2};
  initial forever #4 clock = ~clock;
  gbs_top u_dut (.clock(clock), .sys_rst(sys_rst), .bus_addr(bus_addr),
    .bus_wdata(bus_wdata), .bus_wr(bus_wr), .bus_rd(bus_rd),
    .bus_rdata(bus_rdata), .port0_pin_in(i0), .port0_pin_out(o0),
    .port0_pin_oe(e0), .port1_pin_in(i1), .port1_pin_out(o1),
    .port1_pin_oe(e1), .port2_pin_in(i2), .port2_pin_out(o2),
    .port2_pin_oe(e2));
  gbs_pin_model #(.W(5)) u_p0 (.pin_out(o0), .pin_oe(e0), .pin_in(i0));
  gbs_pin_model #(.W(2)) u_p1 (.pin_out(o1), .pin_oe(e1), .pin_in(i1));
  gbs_pin_model #(.W(7)) u_p2 (.pin_out(o2), .pin_oe(e2), .pin_in(i2));
  task chk(string s, logic [31:0] x, logic [31:0] g);
    n_tests++;
    if (g !== x) begin
      fail_count++;
      $display("MISMATCH %s exp %h got %h", s, x, g);
    end
  endtask
  task wr(logic [31:0] a, logic [31:0] d);
    @(posedge clock);
    bus_wr <= 1'h1;
    bus_addr <= a;
    bus_wdata <= d;
    @(posedge clock);
    bus_wr <= 1'h0;
    #1;
  endtask
  task rd(logic [31:0] a, logic [31:0] x);
    @(posedge clock);
    bus_rd <= 1'h1;
    bus_addr <= a;
    @(posedge clock);
    bus_rd <= 1'h0;
    #1;
    chk("rdata", x, bus_rdata);
  endtask
  task print_verdict();
    if (fail_count == 0 && n_tests > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask
  initial begin
    repeat (3000) @(posedge clock);
    fail_count++;
    print_verdict();
  end
  initial begin
    logic [6:0] m, l;
    repeat (2) @(posedge clock);
    sys_rst <= 1'h0;
    #1;
    chk("rst", 32'h0, 32'({e2, e1, e0, o2, o1, o0}));
    for (int p = 0; p < 3; p++) begin
      m = gbs_pkg::OUT_MASK[p];
      l = m & 7'h7E;
      wr(gbs_pkg::DATA_ADDR[p], 32'h7F000000);
      chk("oe", 32'(m), 32'(pe[p]));
      wr(gbs_pkg::SET_ADDR[p], {9'h0, m, 16'h0});
      chk("set", 32'(m), 32'(po[p]));
      wr(gbs_pkg::CLR_ADDR[p], 32'h00010000);
      chk("clr1", 32'(l), 32'(po[p]));
      wr(gbs_pkg::SET_ADDR[p], 32'h00000000);
      chk("set0", 32'(l), 32'(po[p]));
      repeat (2) @(posedge clock);
      rd(gbs_pkg::DATA_ADDR[p], {1'h0, gbs_pkg::DIR_MASK[p], 1'h0, l,
         9'h0, (l ~^ m) & gbs_pkg::IN_MASK[p]});
      rd(gbs_pkg::SET_ADDR[p], 32'h00000000);
      wr(gbs_pkg::CLR_ADDR[p], {9'h0, m, 16'h0});
      chk("clr", 32'h0, 32'(po[p]));
    end
    wr(gbs_pkg::SET_ADDR[2], 32'h007F0000);
    chk("rsv", 32'h63, 32'(o2));
    wr(gbs_pkg::SET_ADDR[0], 32'h001F0000);
    wr(32'hFFFF0D2C, 32'h007F0000);
    chk("map", 32'h1F, 32'(o0));
    wr(gbs_pkg::DATA_ADDR[0], 32'h00150000);
    chk("oeoff", 32'h0, 32'(e0));
    chk("latch", 32'h15, 32'(o0));
    rd(32'hFFFF0D2C, 32'h00000000);
    print_verdict();
  end
endmodule
